// ==== rtl/asife_pkg.sv ====
// constants, types and helpers of the input front end
// assumes 25 MHz clk and a free audio reference clock
package asife_pkg;

  // timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int WD_STEP_MS  = 2;
  localparam int WD_STEP_CYC = CLK_HZ / 1000 * WD_STEP_MS;
  localparam logic [7:0] SCK_IDLE_CYC = 8'h40;

  // register offsets
  localparam logic [7:0] REG_OSC_SEL = 8'h14;
  localparam logic [7:0] REG_WD_CTRL = 8'h1e;
  localparam logic [7:0] REG_CRC_CNT = 8'h2a;

  // reset values
  localparam logic [7:0] RST_OSC_SEL = 8'h00;
  localparam logic [7:0] RST_WD_CTRL = 8'hfe;
  localparam logic [7:0] RST_CRC_CNT = 8'h00;

  // field positions
  localparam int OSC_SRC_LSB = 1;
  localparam int WD_TMO_LSB  = 1;
  localparam int WD_DIS_BIT  = 0;

  // oscillator tick period minus one, clk cycles
  localparam logic [1:0] OSC_PER_25  = 2'h1;
  localparam logic [1:0] OSC_PER_50  = 2'h0;
  localparam logic [1:0] OSC_PER_12  = 2'h3;

  // i2c target address
  localparam logic [6:0] I2C_ADDR = 7'h58;

  // audio formats on the format pins
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  localparam logic [1:0] FMT_TDM = 2'h3;

  // frame geometry
  localparam int FRAME_W = 28;
  localparam int PAY_W   = 26;
  localparam int LANES   = 8;
  localparam int GPI_N   = 4;
  localparam logic [5:0] WORD_LEN = 6'h18;
  localparam logic [PAY_W-1:0] LFSR_SEED = 26'h0000001;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RACK
  } asife_i2c_st_t;

  // scrambler step
  function automatic logic [PAY_W-1:0] lfsr_step(
    input logic [PAY_W-1:0] s
  );
    return {s[PAY_W-2:0], s[25] ^ s[5] ^ s[1] ^ s[0]};
  endfunction

  // scramble, balance, parity; msb is next disparity
  function automatic logic [FRAME_W:0] frame_enc(
    input logic [PAY_W-1:0] pay,
    input logic [PAY_W-1:0] key,
    input logic             disp
  );
    logic [PAY_W-1:0] s;
    int               n;
    logic             hvy;
    logic             inv;
    s = pay ^ key;
    n = 0;
    for (int i = 0; i < PAY_W; i++) begin
      n = n + int'(s[i]);
    end
    hvy = (n > PAY_W / 2);
    inv = (hvy == disp);
    if (inv) begin
      s = ~s;
    end
    return {hvy ^ inv, s, inv, ^{s, inv}};
  endfunction

endpackage

// ==== rtl/asife_lane.sv ====
// one serial audio data line capture
// assumes bit clock edges found on the sampling clock
`timescale 1ns/1ns
`default_nettype none
module asife_lane
  import asife_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // bit timing
  input  wire logic bit_take,
  input  wire logic word_go,
  input  wire logic keep_all,
  // data
  input  wire logic din,
  output logic      bit_r
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       in_word;

  // msb first: count from word start
  assign cnt_nxt = word_go ? 6'h01 :
                   (cnt_r == WORD_LEN) ? cnt_r : cnt_r + 6'h01;
  // bits past word length read as zero unless keep_all
  assign in_word = word_go | keep_all | (cnt_r < WORD_LEN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
      bit_r <= 1'b0;
    end else if (bit_take) begin
      cnt_r <= cnt_nxt;
      bit_r <= in_word & din;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/asife_top.sv ====
// audio serializer input front end: pin sampling, forward frame,
// i2c register port, side channel watchdog, self-test crc counter
// assumes audio pins are asynchronous; link logic on audio_ref_clk
//
// Operation
// - abort side channel transaction after 2 ms steps
// - watchdog disable bit stops the watchdog
// - self-test back channel crc error count
// - sample audio pins on reference clock
// - carry four general inputs in frame
// - idle reference clock selects internal oscillator
// - two-bit field selects oscillator rate
// - 28-bit frame each reference cycle
// - scramble and dc-balance the payload
// - full duplex control bits beside audio
// - eight data lines, one bit, word clock
// - word select low left, high right
// - two's complement, msb first
// - drop extra bits except right aligned, zero missing bits
// - capture data on bit clock rise
// - left aligned: msb at word select edge
// - control channel reached by i2c port
// - right aligned: lsb before word select edge
`timescale 1ns/1ns
`default_nettype none
module asife_top
  import asife_pkg::*;
#(
  parameter int WD_STEP_CYCLES = WD_STEP_CYC
)
(
  // clocks and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             audio_ref_clk,
  // audio pins
  input  wire logic             serial_bit_clock,
  input  wire logic             word_select_clock,
  input  wire logic [LANES-1:0] audio_din,
  input  wire logic [GPI_N-1:0] general_purpose_inputs,
  input  wire logic [1:0]       audio_format,
  // i2c pins
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  // control side channel
  input  wire logic             cc_fwd_bit,
  input  wire logic             cc_back_bit,
  output logic                  cc_rx_bit,
  input  wire logic             cc_txn_start,
  input  wire logic             cc_txn_done,
  output logic                  cc_txn_abort,
  // self-test
  input  wire logic             builtin_test_mode,
  input  wire logic             crc_err,
  // frames
  output logic [FRAME_W-1:0]    fwd_frame,
  output logic [FRAME_W-1:0]    osc_frame,
  output logic                  osc_frame_stb,
  output logic                  osc_active
);

  // reset release
  logic [1:0] rst_pipe_r;
  logic [1:0] lrst_pipe_r;
  logic       srst_n;
  logic       lrst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_pipe_r <= 2'h0;
    else        rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end

  always_ff @(posedge audio_ref_clk or negedge rst_n) begin
    if (!rst_n) lrst_pipe_r <= 2'h0;
    else        lrst_pipe_r <= {lrst_pipe_r[0], 1'b1};
  end

  assign srst_n = rst_pipe_r[1];
  assign lrst_n = lrst_pipe_r[1];

  // link domain
  logic [16:0]      pins_in;
  logic [16:0]      ls1_r;
  logic [16:0]      ls2_r;
  logic [1:0]       fmt_l;
  logic [GPI_N-1:0] gpi_l;
  logic [LANES-1:0] din_l;
  logic             ws_l;
  logic             bck_l;
  logic             ccf_l;

  // clocks only sampled
  assign pins_in = {audio_format, general_purpose_inputs, audio_din,
                    word_select_clock, serial_bit_clock, cc_fwd_bit};

  always_ff @(posedge audio_ref_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ls1_r <= 17'h00000;
      ls2_r <= 17'h00000;
    end else begin
      ls1_r <= pins_in;
      ls2_r <= ls1_r;
    end
  end

  assign fmt_l = ls2_r[16:15];
  assign gpi_l = ls2_r[14:11];
  assign din_l = ls2_r[10:3];
  assign ws_l  = ls2_r[2];
  assign bck_l = ls2_r[1];
  assign ccf_l = ls2_r[0];

  // word timing
  logic bck_d_r;
  logic ws_cap_r;
  logic i2s_pend_r;
  logic bit_seen_r;
  logic go_seen_r;
  logic bck_rise;
  logic ws_chg;
  logic word_go;
  logic keep_all;

  assign bck_rise = bck_l & ~bck_d_r;
  assign ws_chg   = bck_rise & (ws_l != ws_cap_r);
  // left aligned: msb taken with the edge; i2s and tdm one bit later
  assign word_go  = (fmt_l == FMT_LJ) ? ws_chg :
                    (bck_rise & i2s_pend_r);
  // right aligned words have no known start: pass every bit
  assign keep_all = (fmt_l == FMT_RJ);

  always_ff @(posedge audio_ref_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      bck_d_r    <= 1'b0;
      ws_cap_r   <= 1'b0;
      i2s_pend_r <= 1'b0;
      bit_seen_r <= 1'b0;
      go_seen_r  <= 1'b0;
    end else begin
      bck_d_r    <= bck_l;
      ws_cap_r   <= bck_rise ? ws_l : ws_cap_r;
      i2s_pend_r <= bck_rise ? ws_chg : i2s_pend_r;
      bit_seen_r <= bck_rise;
      go_seen_r  <= word_go;
    end
  end

  // data lines
  logic [LANES-1:0] lane_bits;

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      asife_lane u_lane (
        .clk      (audio_ref_clk),
        .rst_n    (lrst_n),
        .bit_take (bck_rise),
        .word_go  (word_go),
        .keep_all (keep_all),
        .din      (din_l[g]),
        .bit_r    (lane_bits[g])
      );
    end
  endgenerate

  // forward frame, one per reference cycle
  logic [PAY_W-1:0]   pay_l;
  logic [PAY_W-1:0]   lfsr_l_r;
  logic               disp_l_r;
  logic [FRAME_W:0]   enc_l;
  logic [FRAME_W-1:0] fwd_frame_r;

  assign pay_l = {1'b0, 8'h00, gpi_l, ccf_l, ws_cap_r, bck_l,
                  go_seen_r, bit_seen_r, lane_bits};
  assign enc_l = frame_enc(pay_l, lfsr_l_r, disp_l_r);

  always_ff @(posedge audio_ref_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      lfsr_l_r    <= LFSR_SEED;
      disp_l_r    <= 1'b0;
      fwd_frame_r <= 28'h0000000;
    end else begin
      lfsr_l_r    <= lfsr_step(lfsr_l_r);
      disp_l_r    <= enc_l[FRAME_W];
      fwd_frame_r <= enc_l[FRAME_W-1:0];
    end
  end

  assign fwd_frame = fwd_frame_r;

  // activity toggle to clk
  logic [2:0] act_cnt_r;
  logic       act_tog_r;

  always_ff @(posedge audio_ref_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      act_cnt_r <= 3'h0;
      act_tog_r <= 1'b0;
    end else begin
      act_cnt_r <= act_cnt_r + 3'h1;
      act_tog_r <= (act_cnt_r == 3'h7) ? ~act_tog_r : act_tog_r;
    end
  end

  // clk domain
  logic [3:0] cs_in;
  logic [3:0] cs1_r;
  logic [3:0] cs2_r;
  logic [2:0] hist_r;
  logic       scl_s;
  logic       sda_s;
  logic       builtin_test_mode_s;
  logic       scl_h;
  logic       sda_h;
  logic       act_edge;

  assign cs_in = {act_tog_r, scl_i, sda_i, builtin_test_mode};

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      cs1_r  <= 4'h0;
      cs2_r  <= 4'h0;
      hist_r <= 3'h0;
    end else begin
      cs1_r  <= cs_in;
      cs2_r  <= cs1_r;
      hist_r <= cs2_r[3:1];
    end
  end

  assign scl_s    = cs2_r[2];
  assign sda_s    = cs2_r[1];
  assign builtin_test_mode_s   = cs2_r[0];
  assign scl_h    = hist_r[1];
  assign sda_h    = hist_r[0];
  assign act_edge = cs2_r[3] ^ hist_r[2];

  // registers
  logic [7:0] osc_sel_r;
  logic [7:0] wd_ctrl_r;
  logic [7:0] crc_cnt_r;

  // ref loss and oscillator frames
  logic [7:0]         idle_cnt_r;
  logic               osc_active_r;
  logic [1:0]         osc_div_r;
  logic [1:0]         osc_src;
  logic [1:0]         osc_per;
  logic               osc_tick;
  logic [PAY_W-1:0]   pay_o;
  logic [PAY_W-1:0]   lfsr_o_r;
  logic               disp_o_r;
  logic [FRAME_W:0]   enc_o;
  logic [FRAME_W-1:0] osc_frame_r;
  logic               osc_stb_r;

  assign osc_src  = osc_sel_r[OSC_SRC_LSB+1:OSC_SRC_LSB];
  assign osc_per  = (osc_src == 2'h1) ? OSC_PER_50 :
                    (osc_src == 2'h3) ? OSC_PER_12 : OSC_PER_25;
  assign osc_tick = osc_active_r & (osc_div_r == osc_per);
  assign pay_o    = {1'b1, 24'h000000, cc_fwd_bit};
  assign enc_o    = frame_enc(pay_o, lfsr_o_r, disp_o_r);

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      idle_cnt_r   <= 8'h00;
      osc_active_r <= 1'b0;
    end else begin
      idle_cnt_r   <= act_edge ? 8'h00 :
                      (idle_cnt_r == SCK_IDLE_CYC) ? idle_cnt_r :
                      idle_cnt_r + 8'h01;
      osc_active_r <= ~act_edge & (idle_cnt_r == SCK_IDLE_CYC);
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      osc_div_r   <= 2'h0;
      lfsr_o_r    <= LFSR_SEED;
      disp_o_r    <= 1'b0;
      osc_frame_r <= 28'h0000000;
      osc_stb_r   <= 1'b0;
    end else begin
      osc_div_r   <= (osc_tick | ~osc_active_r) ? 2'h0 : osc_div_r + 2'h1;
      osc_stb_r   <= osc_tick;
      if (osc_tick) begin
        lfsr_o_r    <= lfsr_step(lfsr_o_r);
        disp_o_r    <= enc_o[FRAME_W];
        osc_frame_r <= enc_o[FRAME_W-1:0];
      end
    end
  end

  assign osc_frame     = osc_frame_r;
  assign osc_frame_stb = osc_stb_r;
  assign osc_active    = osc_active_r;

  // i2c register port
  asife_i2c_st_t st_r;
  asife_i2c_st_t st_nxt;
  logic [7:0]    sh_r;
  logic [7:0]    sh_nxt;
  logic [2:0]    cnt_r;
  logic [2:0]    cnt_nxt;
  logic [7:0]    ptr_r;
  logic [7:0]    ptr_nxt;
  logic          rw_r;
  logic          rw_nxt;
  logic          first_r;
  logic          first_nxt;
  logic          got_r;
  logic          got_nxt;
  logic          oe_r;
  logic          oe_nxt;
  logic          pin_lo_r;
  logic          start_c;
  logic          stop_c;
  logic          rise_c;
  logic          fall_c;
  logic          wr_hit;
  logic [7:0]    rd_data;

  assign start_c = scl_s & scl_h & sda_h & ~sda_s;
  assign stop_c  = scl_s & scl_h & ~sda_h & sda_s;
  assign rise_c  = scl_s & ~scl_h;
  assign fall_c  = ~scl_s & scl_h;
  assign wr_hit  = (st_r == I_WR) & fall_c & got_r & ~first_r &
                   ~start_c & ~stop_c;
  assign rd_data = (ptr_r == REG_OSC_SEL) ? osc_sel_r :
                   (ptr_r == REG_WD_CTRL) ? wd_ctrl_r :
                   (ptr_r == REG_CRC_CNT) ? crc_cnt_r : 8'h00;

  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = sh_r;
    cnt_nxt   = cnt_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    first_nxt = first_r;
    got_nxt   = got_r;
    oe_nxt    = oe_r;
    if (start_c) begin
      st_nxt  = I_ADDR;
      cnt_nxt = 3'h0;
      got_nxt = 1'b0;
      oe_nxt  = 1'b0;
    end else if (stop_c) begin
      st_nxt = I_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        I_ADDR, I_WR: begin
          if (rise_c) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            cnt_nxt = cnt_r + 3'h1;
            got_nxt = (cnt_r == 3'h7);
          end else if (fall_c & got_r) begin
            got_nxt = 1'b0;
            oe_nxt  = 1'b1;
            st_nxt  = I_ACK;
            if (st_r == I_ADDR) begin
              rw_nxt    = sh_r[0];
              first_nxt = 1'b1;
              if (sh_r[7:1] != I2C_ADDR) begin
                oe_nxt = 1'b0;
                st_nxt = I_IDLE;
              end
            end else if (first_r) begin
              ptr_nxt   = sh_r;
              first_nxt = 1'b0;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        I_ACK: begin
          if (fall_c) begin
            oe_nxt  = 1'b0;
            st_nxt  = I_WR;
            cnt_nxt = 3'h0;
            if (rw_r) begin
              st_nxt  = I_RD;
              sh_nxt  = rd_data;
              oe_nxt  = ~rd_data[7];
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        I_RD: begin
          if (fall_c) begin
            if (cnt_r == 3'h7) begin
              oe_nxt  = 1'b0;
              st_nxt  = I_RACK;
              cnt_nxt = 3'h0;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_r[6];
              cnt_nxt = cnt_r + 3'h1;
            end
          end
        end
        I_RACK: begin
          if (rise_c & sda_s) begin
            st_nxt = I_IDLE;
          end else if (fall_c) begin
            st_nxt  = I_RD;
            sh_nxt  = rd_data;
            oe_nxt  = ~rd_data[7];
            ptr_nxt = ptr_r + 8'h01;
          end
        end
        default: begin
          st_nxt = I_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      st_r     <= I_IDLE;
      sh_r     <= 8'h00;
      cnt_r    <= 3'h0;
      ptr_r    <= 8'h00;
      rw_r     <= 1'b0;
      first_r  <= 1'b0;
      got_r    <= 1'b0;
      oe_r     <= 1'b0;
      pin_lo_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      sh_r     <= sh_nxt;
      cnt_r    <= cnt_nxt;
      ptr_r    <= ptr_nxt;
      rw_r     <= rw_nxt;
      first_r  <= first_nxt;
      got_r    <= got_nxt;
      oe_r     <= oe_nxt;
      pin_lo_r <= 1'b0;
    end
  end

  assign sda_oe = oe_r;
  assign sda_o  = pin_lo_r;
  assign scl_o  = pin_lo_r;
  assign scl_oe = pin_lo_r;

  // register writes; count is read only
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      osc_sel_r <= RST_OSC_SEL;
      wd_ctrl_r <= RST_WD_CTRL;
    end else if (wr_hit) begin
      osc_sel_r <= (ptr_r == REG_OSC_SEL) ? sh_r : osc_sel_r;
      wd_ctrl_r <= (ptr_r == REG_WD_CTRL) ? sh_r : wd_ctrl_r;
    end
  end

  // self-test crc error count, saturating
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) crc_cnt_r <= RST_CRC_CNT;
    else if (builtin_test_mode_s & crc_err & (crc_cnt_r != 8'hff))
      crc_cnt_r <= crc_cnt_r + 8'h01;
  end

  // side channel watchdog
  logic [15:0] step_r;
  logic [6:0]  units_r;
  logic        pend_r;
  logic        abort_r;
  logic        rx_bit_r;
  logic [6:0]  wd_tmo;
  logic        wd_run;
  logic        step_end;
  logic        expire;

  assign wd_tmo   = wd_ctrl_r[WD_TMO_LSB+6:WD_TMO_LSB];
  assign wd_run   = pend_r & ~wd_ctrl_r[WD_DIS_BIT];
  assign step_end = wd_run & (step_r == 16'(WD_STEP_CYCLES - 1));
  // a zero field expires on the first step
  assign expire   = step_end &
                    ({1'b0, units_r} + 8'h01 >= {1'b0, wd_tmo});

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      step_r   <= 16'h0000;
      units_r  <= 7'h00;
      pend_r   <= 1'b0;
      abort_r  <= 1'b0;
      rx_bit_r <= 1'b0;
    end else begin
      step_r   <= (!wd_run | step_end) ? 16'h0000 : step_r + 16'h0001;
      units_r  <= !wd_run ? 7'h00 : step_end ? units_r + 7'h01 : units_r;
      pend_r   <= cc_txn_start | (pend_r & ~cc_txn_done & ~expire);
      abort_r  <= expire;
      rx_bit_r <= cc_back_bit;
    end
  end

  assign cc_txn_abort = abort_r;
  assign cc_rx_bit    = rx_bit_r;

endmodule
`default_nettype wire

// ==== sim/asife_top_checker.sv ====
// checker: watchdog, i2c data pin, parity, fallback
// bound to asife_top ports
`timescale 1ns/1ns
`default_nettype none
module asife_top_checker
  import asife_pkg::*;
#(
  parameter int WD_STEP_CYCLES = WD_STEP_CYC
)
(
  // clocks and reset
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               audio_ref_clk,
  // i2c
  input wire logic               scl_i,
  input wire logic               sda_oe,
  // side channel
  input wire logic               cc_back_bit,
  input wire logic               cc_rx_bit,
  input wire logic               cc_txn_start,
  input wire logic               cc_txn_done,
  input wire logic               cc_txn_abort,
  // frames
  input wire logic [FRAME_W-1:0] fwd_frame,
  input wire logic [FRAME_W-1:0] osc_frame,
  input wire logic               osc_frame_stb,
  input wire logic               osc_active
);
  logic        pend_r;
  logic [23:0] wcnt_r;
  logic [7:0]  idle_r;
  logic        refq_r;

  // pending age
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      wcnt_r <= 24'h000000;
    end else if (cc_txn_start && !pend_r) begin
      pend_r <= 1'b1;
      wcnt_r <= 24'h000001;
    end else if (cc_txn_done || cc_txn_abort) begin
      pend_r <= 1'b0;
    end else begin
      wcnt_r <= wcnt_r + 24'h000001;
    end
  end

  // clk cycles since ref moved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refq_r <= 1'b0;
      idle_r <= 8'h00;
    end else begin
      refq_r <= audio_ref_clk;
      idle_r <= (refq_r != audio_ref_clk) ? 8'h00 :
                idle_r + {7'h00, idle_r != 8'hff};
    end
  end

  AST_ABORT_ONE: assert property (
    @(posedge clk) disable iff (!rst_n) cc_txn_abort |=> !cc_txn_abort)
    else $error("abort too long");
  AST_ABORT_TIME: assert property (
    @(posedge clk) disable iff (!rst_n) cc_txn_abort |-> pend_r &&
    wcnt_r > WD_STEP_CYCLES && (int'(wcnt_r) - 1) % WD_STEP_CYCLES == 0)
    else $error("abort off step");
  AST_SDA_SCL_LOW: assert property (
    @(posedge clk) disable iff (!rst_n) $changed(sda_oe) |-> !scl_i)
    else $error("sda moved while scl high");
  AST_FWD_PARITY: assert property (
    @(posedge audio_ref_clk) disable iff (!rst_n) !(^fwd_frame))
    else $error("fwd parity odd");
  AST_OSC_PARITY: assert property (
    @(posedge clk) disable iff (!rst_n) osc_frame_stb |-> !(^osc_frame))
    else $error("osc parity odd");
  AST_OSC_LATE: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(osc_active) |-> idle_r > 8'h30)
    else $error("early fallback");
  AST_OSC_DUE: assert property (
    @(posedge clk) disable iff (!rst_n) idle_r == 8'h64 |-> osc_active)
    else $error("no fallback");
  AST_RX_FOLLOW: assert property (
    @(posedge clk) disable iff (!rst_n)
    $past(rst_n, 4) |-> cc_rx_bit == $past(cc_back_bit))
    else $error("back bit lost");

  CV_ABORT: cover property (@(posedge clk) cc_txn_abort);
  CV_OSC: cover property (@(posedge clk) $rose(osc_active));
  CV_ACK: cover property (@(posedge clk) $rose(sda_oe));
endmodule

bind asife_top asife_top_checker #(.WD_STEP_CYCLES(WD_STEP_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .audio_ref_clk(audio_ref_clk), .scl_i(scl_i),
  .sda_oe(sda_oe), .cc_back_bit(cc_back_bit), .cc_rx_bit(cc_rx_bit),
  .cc_txn_start(cc_txn_start), .cc_txn_done(cc_txn_done),
  .cc_txn_abort(cc_txn_abort), .fwd_frame(fwd_frame), .osc_frame(osc_frame),
  .osc_frame_stb(osc_frame_stb), .osc_active(osc_active));
`default_nettype wire

// ==== sim/asife_audio_src.sv ====
// audio source model: ref, bit and word clocks, data
// ref clock parks low while ref_en low
`timescale 1ns/1ns
`default_nettype none
module asife_audio_src
  import asife_pkg::*;
(
  // control
  input wire logic         ref_en,
  // audio pins
  output logic             audio_ref_clk,
  output logic             serial_bit_clock,
  output logic             word_select_clock,
  output logic [LANES-1:0] audio_din
);
  logic [2:0]  div_r = 3'h0;
  logic [4:0]  slot_r = 5'h00;
  logic        bit_r = 1'b0, ws_r = 1'b0, bck_r = 1'b0;
  logic [4:0]  nxt;
  logic [23:0] word;

  // left low, right high; two's complement samples
  assign word = ws_r ? 24'h65a3ce : 24'h9a5c31;
  assign nxt = slot_r + 5'h01;
  assign serial_bit_clock = bck_r;
  assign word_select_clock = ws_r;
  assign audio_din = {LANES{bit_r}};

  // 30 ns reference
  initial begin
    audio_ref_clk = 1'b0;
    #7;
    forever #15 audio_ref_clk = ref_en & ~audio_ref_clk;
  end

  // data moves on bit clock fall
  always @(posedge audio_ref_clk) begin
    div_r <= div_r + 3'h1;
    if (div_r == 3'h3) begin
      bck_r <= 1'b1;
    end
    if (div_r == 3'h7) begin
      bck_r <= 1'b0;
      slot_r <= nxt;
      bit_r <= (nxt < 5'h18) ? word[5'h17 - nxt] : 1'b0;
      if (nxt == 5'h1f) begin
        ws_r <= ~ws_r;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/asife_top_test.sv ====
// testbench: register access, watchdog, crc count, fallback
// inputs move on clk fall; audio source model on the pins
`timescale 1ns/1ns
`default_nettype none
module asife_top_test
  import asife_pkg::*;
;
  logic               clk;
  logic               rst_n = 1'b0, ref_en = 1'b1;
  logic               scl_drv = 1'b1, sda_drv = 1'b1;
  logic               cc_back_bit = 1'b0, cc_txn_start = 1'b0;
  logic               cc_txn_done = 1'b0, crc_err = 1'b0;
  logic               builtin_test_mode = 1'b0;
  logic               aref, sbck, wsel, scl_o, scl_oe, sda_o, sda_oe;
  logic               cc_rx_bit, cc_txn_abort, osc_frame_stb, osc_active;
  logic [LANES-1:0]   audio_din;
  logic [FRAME_W-1:0] fwd_frame, osc_frame;
  logic [15:0]        seen;
  logic [15:0]        gap_exp [4] = '{16'h0002, 16'h0001, 16'h0002, 16'h0004};
  int                 failures = 0, tests_run = 0, cycles = 0;
  wire logic          scl_i, sda_i;

  // open drain, pulled up
  assign scl_i = scl_oe ? scl_o & scl_drv : scl_drv;
  assign sda_i = sda_oe ? sda_o & sda_drv : sda_drv;

  asife_audio_src src (.ref_en(ref_en), .audio_ref_clk(aref),
    .serial_bit_clock(sbck), .word_select_clock(wsel), .audio_din(audio_din));
  asife_top #(.WD_STEP_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n),
    .audio_ref_clk(aref), .serial_bit_clock(sbck), .word_select_clock(wsel),
    .audio_din(audio_din), .general_purpose_inputs(4'ha),
    .audio_format(FMT_I2S), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .cc_fwd_bit(1'b1),
    .cc_back_bit(cc_back_bit), .cc_rx_bit(cc_rx_bit),
    .cc_txn_start(cc_txn_start), .cc_txn_done(cc_txn_done),
    .cc_txn_abort(cc_txn_abort), .builtin_test_mode(builtin_test_mode),
    .crc_err(crc_err), .fwd_frame(fwd_frame), .osc_frame(osc_frame),
    .osc_frame_stb(osc_frame_stb), .osc_active(osc_active));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string w, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic drv(input logic c, d);
    scl_drv = c;
    sda_drv = d;
    repeat (16) @(negedge clk);
  endtask

  task automatic i2c_bit(input logic b, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    r = sda_i;
    drv(1'b1, b);
    drv(1'b0, b);
  endtask

  task automatic i2c_start();
    drv(scl_drv, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask

  task automatic i2c_stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask

  task automatic i2c_byte(input logic [7:0] d, output logic [7:0] q,
                          output logic a);
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(d[i], q[i]);
    end
    i2c_bit(1'b1, a);
  endtask

  task automatic reg_wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic [2:0] ak;
    i2c_start();
    i2c_byte(8'hb0, q, ak[0]);
    i2c_byte(a, q, ak[1]);
    i2c_byte(d, q, ak[2]);
    i2c_stop();
    check("write acks", 16'h0000, {13'h0000, ak});
  endtask

  task automatic reg_rd(input logic [7:0] a, e);
    logic [7:0] q;
    logic [2:0] ak;
    logic       nk;
    i2c_start();
    i2c_byte(8'hb0, q, ak[0]);
    i2c_byte(a, q, ak[1]);
    i2c_start();
    i2c_byte(8'hb1, q, ak[2]);
    i2c_byte(8'hff, q, nk);
    i2c_stop();
    check("read acks", 16'h0000, {13'h0000, ak});
    check("register", {8'h00, e}, {8'h00, q});
  endtask

  task automatic wd_run(input logic dn, input int lim, output logic [15:0] s);
    s = 16'h0000;
    cc_txn_start = 1'b1;
    for (int k = 1; k <= lim; k++) begin
      @(negedge clk);
      cc_txn_start = 1'b0;
      cc_txn_done = dn && (k == 4);
      if (cc_txn_abort === 1'b1 && s == 16'h0000) s = k[15:0];
    end
  endtask

  task automatic stb_gap(output logic [15:0] g);
    for (int n = 0; n < 20 && osc_frame_stb !== 1'b1; n++) @(negedge clk);
    g = 16'h0000;
    do begin
      @(negedge clk);
      g++;
    end while (osc_frame_stb !== 1'b1 && g < 16'h0010);
  endtask

  always @(negedge clk) cc_back_bit <= rst_n & ~cc_back_bit;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    reg_rd(REG_OSC_SEL, 8'h00);
    reg_rd(REG_WD_CTRL, 8'hfe);
    reg_rd(REG_CRC_CNT, 8'h00);
    reg_rd(8'h33, 8'h00);
    wd_run(1'b0, 2600, seen);
    check("abort at 127 steps", 16'h09ed, seen);
    reg_wr(REG_WD_CTRL, 8'h06);
    wd_run(1'b0, 100, seen);
    check("abort at 3 steps", 16'h003d, seen);
    wd_run(1'b1, 100, seen);
    check("abort after done", 16'h0000, seen);
    reg_wr(REG_WD_CTRL, 8'h03);
    reg_rd(REG_WD_CTRL, 8'h03);
    wd_run(1'b0, 100, seen);
    check("abort while stopped", 16'h0000, seen);
    for (int m = 0; m < 2; m++) begin
      builtin_test_mode = m[0];
      repeat (5) @(negedge clk);
      repeat (3) begin
        crc_err = 1'b1;
        @(negedge clk);
        crc_err = 1'b0;
        @(negedge clk);
      end
      reg_rd(REG_CRC_CNT, m[0] ? 8'h03 : 8'h00);
    end
    reg_wr(REG_CRC_CNT, 8'h55);
    reg_rd(REG_CRC_CNT, 8'h03);
    ref_en = 1'b0;
    repeat (120) @(negedge clk);
    check("fallback", 16'h0001, {15'h0000, osc_active});
    for (int c = 0; c < 4; c++) begin
      reg_wr(REG_OSC_SEL, {5'h00, c[1:0], 1'b0});
      reg_rd(REG_OSC_SEL, {5'h00, c[1:0], 1'b0});
      stb_gap(seen);
      stb_gap(seen);
      check("frame spacing", gap_exp[c], seen);
    end
    ref_en = 1'b1;
    repeat (120) @(negedge clk);
    check("reference back", 16'h0000, {15'h0000, osc_active});
    report_and_stop();
  end
endmodule
`default_nettype wire
